// file: src/seq_pkg.sv
// constants, types and decode helpers for the reset and boot sequencer
package seq_pkg;

  // register byte offsets on the apb side
  localparam logic [7:0] PM_CTL_OFFSET = 8'h00;
  localparam logic [7:0] RR_CTL_OFFSET = 8'h04;
  localparam logic [7:0] STATUS_OFFSET = 8'h08;

  // field positions
  localparam int PM_PLL_CLOCK_OUTPUT_SEL_BIT = 12;
  localparam int RR_ENABLE_BIT     = 0;
  localparam int ST_BOOT_LSB       = 0;
  localparam int ST_BOOT_BAD_BIT   = 3;
  localparam int ST_RATIO_LSB      = 4;
  localparam int ST_RATIO_BAD_BIT  = 6;
  localparam int ST_RUNNING_BIT    = 7;
  localparam int ST_STATE_LSB      = 8;
  localparam int ST_MULT_LSB       = 10;

  // values after reset
  localparam logic        PLL_CLOCK_OUTPUT_SEL_RESET = 1'b0;
  localparam logic        RR_ENABLE_RESET  = 1'b0;
  localparam logic [31:0] RESET_VECTOR_DEFAULT = 32'h0008_0000;

  // pll lock wait, counted in input clock cycles
  localparam int          LOCK_CYCLES = 4096;
  localparam int          LOCK_CNT_W  = 13;
  localparam logic [12:0] LOCK_LAST   = 13'(LOCK_CYCLES - 1);

  typedef enum logic [1:0]
  {
    ST_HOLD   = 2'b00,
    ST_LOCK   = 2'b01,
    ST_RUN    = 2'b10,
    ST_RUNRST = 2'b11
  } seq_state_t;

  typedef enum logic [2:0]
  {
    BOOT_SPI_SLAVE  = 3'h0,
    BOOT_SPI_MASTER = 3'h1,
    BOOT_PAR_FLASH  = 3'h2,
    BOOT_LINK_PORT  = 3'h4,
    BOOT_NONE       = 3'h7
  } boot_mode_t;

  // boot select code to boot mode; unlisted codes are reserved
  function automatic boot_mode_t decode_boot(input logic [2:0] code);
    boot_mode_t mode;
    mode = BOOT_NONE;
    unique case (code)
      3'h0:    mode = BOOT_SPI_SLAVE;
      3'h1:    mode = BOOT_SPI_MASTER;
      3'h2:    mode = BOOT_PAR_FLASH;
      3'h4:    mode = BOOT_LINK_PORT;
      default: mode = BOOT_NONE;
    endcase
    return mode;
  endfunction

  // start-up ratio code to core/input clock multiple; code 3 is reserved and gives zero
  function automatic logic [5:0] decode_ratio(input logic [1:0] code);
    logic [5:0] mult;
    mult = 6'h00;
    unique case (code)
      2'h0: mult = 6'h06;
      2'h1: mult = 6'h20;
      2'h2: mult = 6'h10;
      2'h3: mult = 6'h00;
    endcase
    return mult;
  endfunction

endpackage

// file: src/lock_timer_if.sv
// handshake between the sequencer and its pll lock timer
`timescale 1ns/1ns
interface lock_timer_if;
  logic start;
  logic abort;
  logic done;

  modport seq
  (
    output start,
    output abort,
    input  done
  );

  modport timer
  (
    input  start,
    input  abort,
    output done
  );
endinterface

// file: src/lock_timer.sv
// counts the pll lock latency after the processor reset is released
`timescale 1ns/1ns
module lock_timer
(
  // clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // control from the sequencer
  lock_timer_if.timer tmr
);

  logic [seq_pkg::LOCK_CNT_W-1:0] count;
  logic                           busy;

  // a start restarts the count; abort wins so a reset glitch never runs on
  always_ff @(posedge clk)
  begin
    if (rst || tmr.abort)
    begin
      busy  <= 1'b0;
      count <= '0;
    end
    else if (tmr.start)
    begin
      busy  <= 1'b1;
      count <= '0;
    end
    else if (busy)
    begin
      count <= count + 1'b1;
      if (count == seq_pkg::LOCK_LAST)
        busy <= 1'b0;
    end
  end

  // one-cycle pulse once the full latency has been counted
  always_ff @(posedge clk)
  begin
    if (rst || tmr.abort)
      tmr.done <= 1'b0;
    else
      tmr.done <= busy && (count == seq_pkg::LOCK_LAST);
  end

endmodule

// file: src/reset_boot_pll_clock_output_sequencer.sv
// processor reset, boot capture and shared clock/reset pin sequencer
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ns

module reset_boot_pll_clock_output_sequencer
(
  // clock and block reset
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // processor pins
  input  wire logic        PROC_RESET_N,
  input  wire logic [2:0]  BOOT_SELECT_CODE,
  input  wire logic [1:0]  STARTUP_RATIO_SELECT,
  // shared clock out / reset out / running reset in pin
  input  wire logic        SHARED_PIN_IN,
  output logic             SHARED_PIN_OUT,
  output logic             SHARED_PIN_OE,
  // core side
  output logic             CORE_RUN,
  output logic             CORE_START,
  output logic [31:0]      CORE_PC_START,
  output logic [2:0]       BOOT_MODE,
  output logic [5:0]       CORE_RATIO,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);

  lock_timer_if tmr_if ();

  seq_pkg::seq_state_t state;
  seq_pkg::seq_state_t next_state;
  logic                pll_clock_output_sel;
  logic                rr_enable;
  logic [2:0]          boot_code;
  logic [1:0]          ratio_code;
  logic                clk_div;
  logic                ctl_clear;
  logic                apb_commit;
  logic                reset_out_n;
  logic [31:0]         status_word;
  logic [31:0]         next_rdata;
  logic                next_slverr;

  lock_timer u_lock_timer
  (
    .clk (REF_CLK),
    .rst (SYS_RST),
    .tmr (tmr_if.timer)
  );

  // the processor reset pin also returns software control to defaults
  assign ctl_clear  = SYS_RST || !PROC_RESET_N;
  assign apb_commit = PSEL && PENABLE && PREADY;

  // timer starts on the first cycle the reset pin is seen high
  assign tmr_if.start = (state == seq_pkg::ST_HOLD) && PROC_RESET_N;
  assign tmr_if.abort = !PROC_RESET_N;

  // sequencing: hold, lock wait, run, and the running-reset hold
  always_comb
  begin
    next_state = state;
    unique case (state)
      seq_pkg::ST_HOLD:
        if (PROC_RESET_N)
          next_state = seq_pkg::ST_LOCK;
      seq_pkg::ST_LOCK:
        if (tmr_if.done)
          next_state = seq_pkg::ST_RUN;
      // wait until the pin is released, so our own drive never reads back
      seq_pkg::ST_RUN:
        if (rr_enable && !SHARED_PIN_OE && !SHARED_PIN_IN)
          next_state = seq_pkg::ST_RUNRST;
      seq_pkg::ST_RUNRST:
        if (!rr_enable || SHARED_PIN_IN)
          next_state = seq_pkg::ST_RUN;
    endcase
    if (!PROC_RESET_N)
      next_state = seq_pkg::ST_HOLD;
  end

  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      state <= seq_pkg::ST_HOLD;
    else
      state <= next_state;
  end

  // latch straps on the release edge only; held until the next reset
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      boot_code  <= 3'h0;
      ratio_code <= 2'h0;
    end
    else if (tmr_if.start)
    begin
      boot_code  <= BOOT_SELECT_CODE;
      ratio_code <= STARTUP_RATIO_SELECT;
    end
  end

  // decoded boot mode and core clock multiple, registered for the core
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      BOOT_MODE  <= seq_pkg::BOOT_NONE;
      CORE_RATIO <= 6'h00;
    end
    else
    begin
      BOOT_MODE  <= seq_pkg::decode_boot(boot_code);
      CORE_RATIO <= seq_pkg::decode_ratio(ratio_code);
    end
  end

  // core released together with reset out; a running reset restarts it
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      CORE_RUN      <= 1'b0;
      CORE_START    <= 1'b0;
      CORE_PC_START <= seq_pkg::RESET_VECTOR_DEFAULT;
    end
    else
    begin
      CORE_RUN      <= (next_state == seq_pkg::ST_RUN);
      CORE_START    <= (next_state == seq_pkg::ST_RUN)
                       && (state != seq_pkg::ST_RUN);
      CORE_PC_START <= seq_pkg::RESET_VECTOR_DEFAULT;
    end
  end

  // stand-in for the pll clock: input clock halved, always running
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
      clk_div <= 1'b0;
    else
      clk_div <= !clk_div;
  end

  // active-low reset out rises with the core release and stays high through the running-reset hold
  assign reset_out_n = (next_state == seq_pkg::ST_RUN)
                       || (next_state == seq_pkg::ST_RUNRST);

  // shared pin: running-reset input overrides both output functions
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      SHARED_PIN_OUT <= 1'b0;
      SHARED_PIN_OE  <= 1'b1;
    end
    else
    begin
      SHARED_PIN_OE  <= !rr_enable;
      SHARED_PIN_OUT <= pll_clock_output_sel ? !clk_div : reset_out_n;
    end
  end

  // control registers; only the documented bits are stored
  always_ff @(posedge REF_CLK)
  begin
    if (ctl_clear)
    begin
      pll_clock_output_sel <= seq_pkg::PLL_CLOCK_OUTPUT_SEL_RESET;
      rr_enable  <= seq_pkg::RR_ENABLE_RESET;
    end
    else if (apb_commit && PWRITE)
    begin
      if (PADDR == seq_pkg::PM_CTL_OFFSET && PSTRB[1])
        pll_clock_output_sel <= PWDATA[seq_pkg::PM_PLL_CLOCK_OUTPUT_SEL_BIT];
      if (PADDR == seq_pkg::RR_CTL_OFFSET && PSTRB[0])
        rr_enable  <= PWDATA[seq_pkg::RR_ENABLE_BIT];
    end
  end

  // status view of latched straps and sequencer progress
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[seq_pkg::ST_BOOT_LSB +: 3]  = boot_code;
    status_word[seq_pkg::ST_BOOT_BAD_BIT]   =
      (seq_pkg::decode_boot(boot_code) == seq_pkg::BOOT_NONE);
    status_word[seq_pkg::ST_RATIO_LSB +: 2] = ratio_code;
    status_word[seq_pkg::ST_RATIO_BAD_BIT]  = (ratio_code == 2'h3);
    status_word[seq_pkg::ST_RUNNING_BIT]    = CORE_RUN;
    status_word[seq_pkg::ST_STATE_LSB +: 2] = state;
    status_word[seq_pkg::ST_MULT_LSB +: 6]  =
      seq_pkg::decode_ratio(ratio_code);
  end

  // read mux; unmapped addresses read zero and flag an error
  always_comb
  begin
    next_rdata  = 32'h0000_0000;
    next_slverr = 1'b0;
    unique case (PADDR)
      seq_pkg::PM_CTL_OFFSET:
        next_rdata[seq_pkg::PM_PLL_CLOCK_OUTPUT_SEL_BIT] = pll_clock_output_sel;
      seq_pkg::RR_CTL_OFFSET:
        next_rdata[seq_pkg::RR_ENABLE_BIT] = rr_enable;
      seq_pkg::STATUS_OFFSET:
        next_rdata = status_word;
      default:
        next_slverr = 1'b1;
    endcase
  end

  // one wait state: ready is raised on the second access cycle, then dropped
  always_ff @(posedge REF_CLK)
  begin
    if (SYS_RST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY  <= PSEL && PENABLE && !PREADY;
      PRDATA  <= (PSEL && !PWRITE) ? next_rdata : 32'h0000_0000;
      PSLVERR <= PSEL && PENABLE && !PREADY && next_slverr;
    end
  end

endmodule

// file: testbench/seq_properties.sv
// port checks for the reset and boot sequencer
`timescale 1ns/1ns
module seq_properties
(
  // clock and reset
  input wire logic        REF_CLK,
  input wire logic        SYS_RST,
  // pins and core side
  input wire logic        PROC_RESET_N,
  input wire logic [2:0]  BOOT_SELECT_CODE,
  input wire logic [1:0]  STARTUP_RATIO_SELECT,
  input wire logic        SHARED_PIN_IN,
  input wire logic        SHARED_PIN_OUT,
  input wire logic        SHARED_PIN_OE,
  input wire logic        CORE_RUN,
  input wire logic        CORE_START,
  input wire logic [31:0] CORE_PC_START,
  input wire logic [2:0]  BOOT_MODE,
  input wire logic [5:0]  CORE_RATIO,
  // apb
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0]  PSTRB,
  input wire logic        PREADY
);
  logic [12:0] cnt;
  logic        seen;
  logic        sel;
  logic        rr;
  logic [2:0]  lb;
  logic [1:0]  lr;
  wire         wr = PSEL && PENABLE && PREADY && PWRITE;
  wire         clr = SYS_RST || !PROC_RESET_N;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // cycles since release; frozen after first run so restarts skip it
  always_ff @(posedge REF_CLK)
    if (clr) cnt <= 13'h0;
    else if (!seen && !CORE_RUN) cnt <= cnt + 13'h1;
  always_ff @(posedge REF_CLK)
    if (clr) seen <= 1'b0;
    else if (CORE_RUN) seen <= 1'b1;
  // shadow of the two control bits, cleared by either reset
  always_ff @(posedge REF_CLK)
    if (clr)
    begin
      sel <= 1'b0;
      rr  <= 1'b0;
    end
    else if (wr && PADDR == 8'h00 && PSTRB[1]) sel <= PWDATA[12];
    else if (wr && PADDR == 8'h04 && PSTRB[0]) rr <= PWDATA[0];
  // straps follow the pins while reset is held
  always_ff @(posedge REF_CLK)
    if (clr)
    begin
      lb <= BOOT_SELECT_CODE;
      lr <= STARTUP_RATIO_SELECT;
    end
  a_lock_wait: assert property ($rose(CORE_RUN) && !seen |->
    cnt >= 13'h1001 && cnt <= 13'h1003) else $error("lock wait length");
  a_start_vector: assert property (CORE_START |-> CORE_RUN &&
    CORE_PC_START == seq_pkg::RESET_VECTOR_DEFAULT ##1 !CORE_START)
    else $error("start pulse or vector");
  a_run_start: assert property ($rose(CORE_RUN) |-> CORE_START)
    else $error("run without start");
  a_reset_out: assert property (!sel && !$past(sel) && !rr &&
    !$past(rr) |-> SHARED_PIN_OE && SHARED_PIN_OUT == CORE_RUN)
    else $error("reset out level");
  a_pll_clock: assert property (sel && $past(sel, 2) |->
    SHARED_PIN_OUT != $past(SHARED_PIN_OUT)) else $error("clock out");
  a_pin_dir: assert property (rr == $past(rr) |->
    SHARED_PIN_OE == !rr) else $error("pin direction");
  a_run_drop: assert property (rr && $past(rr, 2) && CORE_RUN &&
    !SHARED_PIN_IN |-> ##[1:2] !CORE_RUN) else $error("running reset");
  a_ratio_map: assert property (CORE_RUN |-> CORE_RATIO ==
    (lr == 2'h0 ? 6'h06 : lr == 2'h1 ? 6'h20 : lr == 2'h2 ? 6'h10 : 6'h00))
    else $error("ratio decode");
  a_boot_map: assert property (CORE_RUN |-> BOOT_MODE ==
    (lb inside {3'h0, 3'h1, 3'h2, 3'h4} ? lb : 3'h7))
    else $error("boot decode");
endmodule

// file: testbench/board_model.sv
// board supervisor: processor reset and running reset drive
`timescale 1ns/1ns
module board_model
(
  // bench requests
  input wire logic clk,
  input wire logic hold,
  input wire logic pull_low,
  // board pins
  output logic     reset_n,
  output logic     rr_drive
);
  // low from power-up; lags the request so straps settle first
  initial reset_n = 1'b0;
  always @(posedge clk)
    reset_n <= !hold;
  // open drain with pull-up: released line reads high
  assign rr_drive = !pull_low;
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the reset and boot sequencer
`timescale 1ns/1ns
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, hold = 1'b1, pull_low = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [2:0]  boot = 3'h0, bmode;
  logic [1:0]  ratio = 2'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, pc, seed = 32'h9AB2;
  logic [5:0]  cratio;
  logic        rst_n, rr_drive, pin_in, pout, oe, run, cstart;
  logic        pready, pslverr;
  logic [33:0] q_apb[$];
  logic [8:0]  q_st[$];
  int          n_fail = 0, samples_checked = 0;
  // steady clock, never stopped
  always #20 clk = !clk;
  assign pin_in = oe ? pout : rr_drive;
  board_model brd_u (.clk(clk), .hold(hold), .pull_low(pull_low),
    .reset_n(rst_n), .rr_drive(rr_drive));
  reset_boot_pll_clock_output_sequencer dut_u
  (
    .REF_CLK(clk), .SYS_RST(rst), .PROC_RESET_N(rst_n),
    .BOOT_SELECT_CODE(boot), .STARTUP_RATIO_SELECT(ratio),
    .SHARED_PIN_IN(pin_in), .SHARED_PIN_OUT(pout), .SHARED_PIN_OE(oe),
    .CORE_RUN(run), .CORE_START(cstart), .CORE_PC_START(pc),
    .BOOT_MODE(bmode), .CORE_RATIO(cratio), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(4'hF), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr)
  );
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [5:0] mul(logic [1:0] r);
    return r == 2'h0 ? 6'h06 : r == 2'h1 ? 6'h20 : r == 2'h2 ? 6'h10 : 6'h00;
  endfunction
  function automatic logic [2:0] bm(logic [2:0] b);
    return b inside {3'h0, 3'h1, 3'h2, 3'h4} ? b : 3'h7;
  endfunction
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one apb transfer; e is {check data, slave error, read data}
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] e);
    int k;
    q_apb.push_back(e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_fail++; // a missing bus answer is a failure
      stop_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for the core to run; gives cycles waited
  task automatic wait_run(int lim, output int k);
    k = 0;
    while (run !== 1'b1 && k < lim)
    begin
      @(posedge clk);
      k++;
      if (k == 2000) chk("reset_out", 32'h0, {run, pout});
    end
    if (run !== 1'b1) n_fail++;
  endtask
  // monitor: each answer takes the oldest note
  always @(posedge clk)
  begin
    logic [33:0] e;
    logic [8:0]  s;
    if (pready === 1'b1)
    begin
      e = q_apb.pop_front();
      chk("pslverr", e[32], pslverr);
      if (e[33]) chk("prdata", e[31:0], prdata);
    end
    if (cstart === 1'b1)
    begin
      chk("start_note", 32'h1, q_st.size() > 0);
      s = q_st.pop_front();
      chk("boot_mode", s[8:6], bmode);
      chk("ratio", s[5:0], cratio);
      chk("vector", 32'h0008_0000, pc);
    end
  end
  initial
  begin
    int k;
    logic [31:0] d;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0, {2'b10, 32'h0});
    apb(1'b0, 8'h0C, 32'h0, {2'b11, 32'h0});
    // release then abort mid-wait: no start may follow
    hold <= 1'b0;
    repeat (1000) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      boot <= i[2:0]; // straps valid before reset is asserted
      ratio <= i[1:0];
      q_st.push_back({bm(i[2:0]), mul(i[1:0])});
      @(posedge clk);
      hold <= 1'b1;
      repeat (4) @(posedge clk);
      hold <= 1'b0;
      wait_run(5000, k);
      chk("lock_wait", 32'h1, k >= 4096 && k <= 4100);
      chk("reset_out_up", 32'h1, pout);
      boot <= ~i[2:0];
      ratio <= ~i[1:0];
      apb(1'b0, 8'h08, 32'h0, {2'b10, 16'h0, mul(i[1:0]), 2'h2, 1'b1,
        i[1:0] == 2'h3, i[1:0], bm(i[2:0]) == 3'h7, i[2:0]});
    end
    apb(1'b1, 8'h00, rnd() | 32'h1000, {2'b00, 32'h0});
    apb(1'b0, 8'h00, 32'h0, {2'b10, 32'h1000});
    d[0] = pout;
    @(posedge clk);
    chk("pll_clock", !d[0], pout);
    apb(1'b1, 8'h00, rnd() & ~32'h1000, {2'b00, 32'h0});
    apb(1'b1, 8'h04, rnd() | 32'h1, {2'b00, 32'h0});
    apb(1'b0, 8'h04, 32'h0, {2'b10, 32'h1});
    chk("pin_oe", 32'h0, oe);
    q_st.push_back({3'h7, 6'h00});
    pull_low <= 1'b1;
    repeat (3) @(posedge clk);
    chk("run_drop", 32'h0, run);
    pull_low <= 1'b0;
    wait_run(50, k);
    hold <= 1'b1;
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h04, 32'h0, {2'b10, 32'h0});
    stop_test();
  end
endmodule
bind reset_boot_pll_clock_output_sequencer seq_properties chk_u (.*);
